// >>> src/mrc_reset_ctrl.sv
// Reset sequencer with AHB-Lite control and status registers
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
module mrc_reset_ctrl
  import mrc_pkg::*;
#(
  parameter int WDT_CYC = mrc_pkg::WDT_PERIOD_CYC
)(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ext_reset_n_in,
  input  wire logic        brownout_low_in,
  input  wire logic        halt_exec_in,
  input  wire logic        wake_in,
  input  wire logic        wdt_clear_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic             core_rst_out,
  output logic             core_run_out,
  output logic             pc_sp_clear_out,
  output logic             port_preset_out,
  output logic             intr_off_out,
  output logic             tmr_off_out,
  output logic             presc_clear_out,
  output logic             sp_top_out,
  output logic             timeout_flag_out,
  output logic             powerdown_flag_out,
  output logic             port_a_bit_seven_out,
  output logic [1:0]       brownout_threshold_out
);
  import mrc_pkg::*;

  mrc_state_t       state_q;
  logic             ext_s1_q;
  logic             ext_s2_q;
  logic             bo_s1_q;
  logic             bo_s2_q;
  logic [CNT_W-1:0] bo_cnt_q;
  logic             bo_trip;
  logic [CNT_W-1:0] su_cnt_q;
  logic [31:0]      wdt_cnt_q;
  logic             wdt_to;
  logic             line_low;
  logic [3:0]       ctrl_q;
  logic             to_q;
  logic             pd_q;
  logic             rst_q;
  logic             run_q;
  logic             pcsp_q;
  logic             a7_q;
  logic             wr_pend_q;
  logic [7:0]       wr_addr_q;
  logic [31:0]      rdata_q;
  logic             su_done;
  logic             addr_ok;
  logic [31:0]      rd_val;

  // Two-stage synchronisers for the reset line and supply monitor
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      bo_s1_q  <= 1'b0;
      bo_s2_q  <= 1'b0;
    end
    else
    begin
      ext_s1_q <= ext_reset_n_in;
      ext_s2_q <= ext_s1_q;
      bo_s1_q  <= brownout_low_in;
      bo_s2_q  <= bo_s1_q;
    end
  end

  // Pin counts as reset only when the option selects it
  assign line_low = ctrl_q[CTRL_PIN_RST] & ~ext_s2_q;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      a7_q <= 1'b1;
    else if (!ctrl_q[CTRL_PIN_RST])
      a7_q <= ext_s2_q;
    else
      a7_q <= 1'b1;
  end

  // Brown-out filter: trips only after a dip outlasts the minimum
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      bo_cnt_q <= '0;
    else if (!(ctrl_q[CTRL_BO_EN] && bo_s2_q))
      bo_cnt_q <= '0;
    else if (bo_cnt_q <= CNT_W'(BO_MIN_CYC))
      bo_cnt_q <= bo_cnt_q + 1'b1;
  end

  assign bo_trip = (bo_cnt_q > CNT_W'(BO_MIN_CYC));

  // Watchdog counter, cleared by reset, service, power-down and timeout, counts only in S_RUN and S_HALT
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      wdt_cnt_q <= '0;
    else if (rst_q || wdt_clear_in || halt_exec_in || wdt_to)
      wdt_cnt_q <= '0;
    else if (state_q == S_RUN || state_q == S_HALT)
      wdt_cnt_q <= wdt_cnt_q + 1'b1;
  end

  assign wdt_to = (wdt_cnt_q == 32'(WDT_CYC - 1));

  // Startup timer
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      su_cnt_q <= '0;
    else if (state_q == S_START || state_q == S_WAKE)
      su_cnt_q <= su_cnt_q + 1'b1;
    else
      su_cnt_q <= '0;
  end

  assign su_done = (su_cnt_q == CNT_W'(STARTUP_CYC - 1));

  // Sequencer
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state_q <= S_POR;
    else
    begin
      case (state_q)
        S_POR:   state_q <= S_HOLD;
        S_HOLD:
          if (!line_low && !bo_trip)
            state_q <= S_START;
        S_START:
          if (line_low || bo_trip)
            state_q <= S_HOLD;
          else if (su_done)
            state_q <= S_RUN;
        S_RUN:
          if (line_low || bo_trip)
            state_q <= S_HOLD;
          else if (wdt_to)
            state_q <= S_START;
          else if (halt_exec_in)
            state_q <= S_HALT;
        S_HALT:
          if (line_low || bo_trip)
            state_q <= S_HOLD;
          else if (wdt_to)
            state_q <= S_WAKE;
          else if (wake_in)
            state_q <= S_RUN;
        S_WAKE:
          if (line_low || bo_trip)
            state_q <= S_HOLD;
          else if (su_done)
            state_q <= S_RUN;
        default: state_q <= S_POR;
      endcase
    end
  end

  // Reset-cause flags
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      to_q <= 1'b0;
      pd_q <= 1'b0;
    end
    else if (state_q == S_HALT && (line_low || bo_trip))
    begin
      to_q <= 1'b0;
      pd_q <= 1'b1;
    end
    else if (state_q == S_HALT && wdt_to)
    begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end
    else if (state_q == S_RUN && (line_low || bo_trip))
      to_q <= 1'b0;
    else if (state_q == S_RUN && wdt_to)
      to_q <= 1'b1;
    else if (state_q == S_RUN && halt_exec_in)
    begin
      to_q <= 1'b0;
      pd_q <= 1'b1;
    end
  end

  // Core controls, released synchronously after the startup delay
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rst_q  <= 1'b1;
      run_q  <= 1'b0;
      pcsp_q <= 1'b0;
    end
    else
    begin
      rst_q  <= (state_q == S_POR) || (state_q == S_HOLD) ||
                (state_q == S_RUN && (line_low || bo_trip || wdt_to)) ||
                (state_q == S_HALT && (line_low || bo_trip)) ||
                ((state_q == S_START || state_q == S_WAKE) &&
                 (line_low || bo_trip)) ||
                (state_q == S_START && !su_done);
      run_q  <= (state_q == S_RUN && !(line_low || bo_trip || wdt_to ||
                 halt_exec_in)) ||
                ((state_q == S_START || state_q == S_WAKE) && su_done &&
                 !(line_low || bo_trip)) ||
                (state_q == S_HALT && wake_in &&
                 !(line_low || bo_trip || wdt_to));
      pcsp_q <= (state_q == S_HALT) && wdt_to &&
                !(line_low || bo_trip);
    end
  end

  assign core_rst_out       = rst_q;
  assign core_run_out       = run_q;
  assign pc_sp_clear_out    = pcsp_q;
  assign port_preset_out    = rst_q;
  assign intr_off_out       = rst_q;
  assign tmr_off_out        = rst_q;
  assign presc_clear_out    = rst_q;
  assign sp_top_out         = rst_q;
  assign timeout_flag_out   = to_q;
  assign powerdown_flag_out = pd_q;
  assign port_a_bit_seven_out   = a7_q;
  assign brownout_threshold_out = ctrl_q[CTRL_BO_THR_LO +: BO_THR_W];

  // AHB-Lite slave, zero wait states, always OKAY
  assign addr_ok = hsel_in && hready_in && htrans_in[1];

  always_comb
  begin
    rd_val = '0;
    if (haddr_in[ADDR_LSB_W-1:0] == ADDR_CTRL)
      rd_val[3:0] = ctrl_q;
    else if (haddr_in[ADDR_LSB_W-1:0] == ADDR_STATUS)
    begin
      rd_val[ST_TIMEOUT]   = to_q;
      rd_val[ST_POWERDOWN] = pd_q;
      rd_val[ST_IN_RESET]  = rst_q;
      rd_val[ST_STATE_LO +: 3] = state_q;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rdata_q   <= '0;
    end
    else if (hready_in)
    begin
      wr_pend_q <= addr_ok && hwrite_in;
      wr_addr_q <= haddr_in[ADDR_LSB_W-1:0];
      rdata_q   <= (addr_ok && !hwrite_in) ? rd_val : 32'h0000_0000;
    end
  end

  // Option register: reset pin select, brown-out enable, threshold
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      ctrl_q <= CTRL_RESET;
    else if (wr_pend_q && wr_addr_q == ADDR_CTRL)
      ctrl_q <= hwdata_in[3:0];
  end

  assign hrdata_out    = rdata_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  // Checks
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  chk_run_line_reset: assert property (
    state_q == S_RUN && line_low |=> core_rst_out && !core_run_out)
    else $error("line low while running did not reset core");
  chk_line_flags: assert property (
    state_q == S_RUN && line_low |=> !timeout_flag_out &&
      powerdown_flag_out == $past(pd_q))
    else $error("line reset flags wrong");
  chk_wdt_run_flags: assert property (
    state_q == S_RUN && !line_low && !bo_trip && wdt_to |=>
      timeout_flag_out && core_rst_out &&
      powerdown_flag_out == $past(pd_q))
    else $error("watchdog run reset wrong");
  chk_wdt_halt: assert property (
    state_q == S_HALT && !line_low && !bo_trip && wdt_to |=>
      pc_sp_clear_out && timeout_flag_out && powerdown_flag_out &&
      !core_rst_out ##1 !pc_sp_clear_out)
    else $error("watchdog halt wake wrong");
  chk_halt_flags: assert property (
    state_q == S_RUN && halt_exec_in && !line_low && !bo_trip &&
      !wdt_to |=> powerdown_flag_out && !timeout_flag_out && !core_run_out)
    else $error("power-down flags wrong");
  chk_halt_wake_line: assert property (
    state_q == S_HALT && line_low |=> !timeout_flag_out &&
      powerdown_flag_out)
    else $error("line wake flags wrong");
  chk_startup_len: assert property (
    state_q == S_HOLD && !line_low && !bo_trip ##1
      (!line_low && !bo_trip) [*3] |-> core_rst_out)
    else $error("reset released before startup delay");
  chk_bo_filter: assert property (
    $rose(bo_s2_q) && ctrl_q[CTRL_BO_EN] |-> !bo_trip [*3])
    else $error("short brown-out dip tripped");
  chk_bo_disabled: assert property (
    !ctrl_q[CTRL_BO_EN] && bo_s2_q && state_q == S_RUN && !line_low &&
      !wdt_to |=> !core_rst_out)
    else $error("brown-out acted while disabled");
  chk_pin_option: assert property (
    !ctrl_q[CTRL_PIN_RST] && !ext_s2_q && state_q == S_RUN && !bo_trip &&
      !wdt_to |=> !core_rst_out)
    else $error("pin reset acted while not selected");
  chk_wdt_cleared: assert property (
    $fell(rst_q) |-> wdt_cnt_q <= 32'd1)
    else $error("watchdog not cleared at reset");

  cov_wdt_halt: cover property (state_q == S_HALT ##1 pcsp_q);
  cov_run_reset: cover property (state_q == S_RUN ##1 state_q == S_HOLD);
  cov_bo_trip: cover property ($rose(bo_trip));
  cov_boot: cover property ($fell(rst_q) ##1 run_q);
endmodule : mrc_reset_ctrl

// >>> src/mrc_pkg.sv
// Constants, states and register map of the reset sequencer
package mrc_pkg;
  localparam int          CLK_PERIOD_NS    = 10;
  localparam int          STARTUP_DELAY_NS = 1000;
  localparam int          BO_MIN_NS        = 1000;
  localparam int          STARTUP_CYC      =
    (STARTUP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          BO_MIN_CYC       =
    (BO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WDT_PERIOD_CYC   = 65536;
  localparam int          CNT_W            = 20;

  localparam logic [7:0]  ADDR_CTRL        = 8'h00;
  localparam logic [7:0]  ADDR_STATUS      = 8'h04;
  localparam int          ADDR_LSB_W       = 8;

  localparam int          CTRL_PIN_RST     = 0;
  localparam int          CTRL_BO_EN       = 1;
  localparam int          CTRL_BO_THR_LO   = 2;
  localparam int          BO_THR_W         = 2;
  localparam logic [3:0]  CTRL_RESET       = 4'h3;

  localparam int          ST_TIMEOUT       = 0;
  localparam int          ST_POWERDOWN     = 1;
  localparam int          ST_IN_RESET      = 2;
  localparam int          ST_STATE_LO      = 4;

  typedef enum logic [2:0] {
    S_POR   = 3'h0,
    S_HOLD  = 3'h1,
    S_START = 3'h2,
    S_RUN   = 3'h3,
    S_HALT  = 3'h4,
    S_WAKE  = 3'h5
  } mrc_state_t;
endpackage : mrc_pkg

// >>> test/mrc_reset_switch.sv
// Reset switch with pull-up RC network on the external reset line
module mrc_reset_switch #(
  parameter int RC_CYC = 30
)(
  input  wire logic clk_in,
  output logic      line_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // RC network keeps the line low while the supply settles
  initial
  begin
    line_out = 1'b0;
    repeat (RC_CYC) @(posedge clk_in);
    line_out <= 1'b1;
  end

  // Switch pulls the line low, pull-up restores it on release
  task automatic press(input int cyc);
    line_out <= 1'b0;
    repeat (cyc) @(posedge clk_in);
    line_out <= 1'b1;
  endtask : press
endmodule : mrc_reset_switch

// >>> test/mrc_reset_ctrl_test.sv
// Self-checking bench of the reset sequencer
module mrc_reset_ctrl_test
  import mrc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WDT = 64;
  localparam int SC  = STARTUP_CYC;
  localparam int TAIL = 5;
  logic        clk = 1'b0, rst = 1'b1, brn = 1'b0, halt = 1'b0;
  logic        wclr = 1'b0, hsel = 1'b0, hwr = 1'b0, wake = 1'b0;
  logic [2:0]  hsz = 3'h2;
  logic [1:0]  htr = 2'h0, th, thr;
  logic [31:0] ha = 32'h0, hwd = 32'h0, hrd, rd;
  logic        hrdy, hresp, crst, run, pcsp, pp, io, tm, pr, sp;
  logic        tof, powerdown_flag, a7, line;
  int          err_count = 0, n_checks = 0, to_m = 0, pd_m = 0;
  int          seed = 32'hf635, n, m, kc = 0;
  logic        kick = 1'b0;

  always #5 clk = ~clk;

  // Periodic watchdog service while kick is set
  always @(posedge clk)
  begin
    kc   <= kc + 1;
    wclr <= kick && (kc % 16 == 0);
  end

  mrc_reset_switch sw_i (.clk_in(clk), .line_out(line));

  mrc_reset_ctrl #(.WDT_CYC(WDT)) mrc_reset_ctrl_i (
    .core_clk_in(clk), .rst_in(rst), .ext_reset_n_in(line),
    .brownout_low_in(brn), .halt_exec_in(halt), .wake_in(wake),
    .wdt_clear_in(wclr), .hsel_in(hsel), .haddr_in(ha), .htrans_in(htr),
    .hwrite_in(hwr), .hsize_in(hsz), .hwdata_in(hwd), .hready_in(hrdy),
    .hrdata_out(hrd), .hreadyout_out(hrdy), .hresp_out(hresp),
    .core_rst_out(crst), .core_run_out(run), .pc_sp_clear_out(pcsp),
    .port_preset_out(pp), .intr_off_out(io), .tmr_off_out(tm),
    .presc_clear_out(pr), .sp_top_out(sp), .timeout_flag_out(tof),
    .powerdown_flag_out(powerdown_flag), .port_a_bit_seven_out(a7),
    .brownout_threshold_out(thr));

  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rdy;
    m = 0;
    do @(posedge clk); while (hrdy !== 1'b1 && m++ < 50);
  endtask : rdy

  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    ha   <= a;
    htr  <= 2'h2;
    hwr  <= w;
    hsz  <= 3'h2;
    rdy();
    htr  <= 2'h0;
    hwd  <= d;
    rdy();
    rd = hrd;
    chk("hresp", 0, hresp);
    hsel <= 1'b0;
  endtask : bus

  // Core-side reset outputs all follow one level
  task automatic core(input logic e);
    chk("core outs", {6{e}}, {crst, pp, io, tm, pr, sp});
    chk("core run", !e, run);
  endtask : core

  task automatic st;
    bus(32'h4, 1'b0, 32'h0);
    chk("status", 32'h30 | (pd_m << 1) | to_m, rd);
    chk("timeout flag", to_m, tof);
    chk("powerdown flag", pd_m, powerdown_flag);
  endtask : st

  task automatic wt(ref logic s, input logic v, input int hi);
    n = 0;
    while (s !== v && n < hi)
    begin
      @(posedge clk);
      #1 n++;
    end
    chk("wait", v, s);
  endtask : wt

  // Lag is the number of cycles already spent since the cause went away
  task automatic restart(input int lag = 0);
    wt(run, 1'b1, SC + 20);
    chk("startup", 1, n + lag >= SC && n + lag <= SC + 8);
    core(1'b0);
  endtask : restart

  task automatic dip(input int len);
    @(posedge clk);
    brn <= 1'b1;
    repeat (len) @(posedge clk);
    brn <= 1'b0;
    repeat (TAIL) @(posedge clk);
    #1;
  endtask : dip

  // Non-reset wake from power-down resumes with flags untouched
  task automatic wake_now;
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    #1 chk("woken run", 1, run);
    chk("woken rst", 0, crst);
    chk("wake flags", {pd_m[0], to_m[0]}, {powerdown_flag, tof});
  endtask : wake_now

  task automatic halt_now;
    @(posedge clk);
    halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    #1 pd_m = 1;
    to_m = 0;
    chk("halted run", 0, run);
    chk("halt flags", 2'b10, {powerdown_flag, tof});
  endtask : halt_now

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    #100_000;
    err_count++;
    wrap_up();
  end

  initial
  begin
    repeat (10) @(posedge clk);
    #1 core(1'b1);
    chk("pin value", 1, a7);
    @(posedge clk);
    rst <= 1'b0;
    wt(run, 1'b1, 300);
    chk("power-on start", 1, n >= SC + 18 && n <= SC + 28);
    core(1'b0);
    st();
    bus(32'h0, 1'b0, 32'h0);
    chk("ctrl", 32'h3, rd);
    bus(32'h8, 1'b0, 32'h0);
    chk("unmapped", 0, rd);
    kick <= 1'b1;
    halt_now();
    wake_now();
    halt_now();
    @(posedge clk);
    sw_i.press(5);
    restart();
    st();
    @(posedge clk);
    sw_i.press(10);
    #1 core(1'b1);
    restart();
    st();
    dip(BO_MIN_CYC - {$random(seed)} % 40);
    chk("short dip", 0, crst);
    dip(BO_MIN_CYC + 10);
    chk("long dip", 1, crst);
    restart(TAIL);
    st();
    th = $random(seed);
    bus(32'h0, 1'b1, {th, 2'b01});
    bus(32'h0, 1'b0, 32'h0);
    chk("ctrl", {th, 2'b01}, rd);
    chk("threshold", th, thr);
    dip(BO_MIN_CYC + 10);
    chk("disabled dip", 0, crst);
    bus(32'h0, 1'b1, {th, 2'b10});
    fork
      sw_i.press(20);
      begin
        repeat (10) @(posedge clk);
        #1 chk("pin value", 0, a7);
        chk("pin ignored", 0, crst);
      end
    join
    bus(32'h0, 1'b1, 32'h3);
    kick <= 1'b0;
    sw_i.press(5);
    restart();
    wt(crst, 1'b1, WDT + 10);
    chk("wdt cycles", 1, n >= WDT - 3 && n <= WDT + 3);
    to_m = 1;
    restart();
    st();
    halt_now();
    wt(pcsp, 1'b1, WDT + 10);
    chk("halt wdt cycles", 1, n >= WDT - 3 && n <= WDT + 3);
    chk("halt wdt rst", 0, crst);
    @(posedge clk);
    #1 chk("halt wdt flags", 2'b11, {powerdown_flag, tof});
    chk("pc sp pulse", 0, pcsp);
    to_m = 1;
    wt(run, 1'b1, SC + 20);
    kick <= 1'b1;
    st();
    wrap_up();
  end
endmodule : mrc_reset_ctrl_test
